// *** src/lsa_pkg.sv ***
package lsa_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_LED_MODE  = 8'h04;
  localparam logic [7:0] ADDR_LED_LATCH = 8'h08;
  localparam logic [7:0] ADDR_RLY_LATCH = 8'h0C;
  localparam logic [7:0] ADDR_SCD_LATCH = 8'h10;
  localparam logic [7:0] ADDR_TRP_LATCH = 8'h14;
  localparam logic [7:0] ADDR_OFFDELAY  = 8'h18;
  localparam logic [7:0] ADDR_STATUS    = 8'h1C;

  // Control register fields
  localparam int CTRL_REMOTE_EN_BIT = 0;
  localparam int CTRL_SW_ALL_LED    = 1;
  localparam int CTRL_SW_ALL_RLY    = 2;
  localparam int CTRL_SW_ALL_SCD    = 3;

  // Reset values
  localparam logic        REMOTE_EN_RST  = 1'b0;
  localparam logic [31:0] LED_MODE_RST   = 32'h0000_0000;
  localparam logic [31:0] OFFDELAY_RST   = 32'h0000_0000;

  // Off-delay tick: 1 ms at 200 MHz
  localparam int CLK_HZ        = 200_000_000;
  localparam int OFF_TICK_US   = 1000;
  localparam int OFF_TICK_CYC  = (CLK_HZ / 1_000_000) * OFF_TICK_US;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } lsa_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } lsa_wb_rsp_t;

endpackage

// *** src/lsa_latched_state_ack.sv ***
// Behaviour
// - Own ack source clears that LED latch
// - Own ack source clears that relay latch
// - Own ack source clears switchgear trip latch
// - Remote disabled: collective sources are ignored
// - Remote disabled: SCADA ack requests rejected
// - Collective source clears all relay latches
// - Collective source clears all SCADA latches
// - Protection alarm clears alarm-mode LED latches
// - Alarm clearing selectable per LED mode
// - Collective source clears all LED latches
// - Clear only once setting signal inactive
// - Relay latch releases after off-delay elapses
module lsa_latched_state_ack
  import lsa_pkg::*;
#(
  parameter int NUM_LED = 16,
  parameter int NUM_RLY = 16,
  parameter int NUM_SCD = 16,
  parameter int NUM_SG  = 4,
  parameter int OFF_W   = 16
) (
  input  wire logic               ref_clk,
  input  wire logic               reset_n,
  input  wire lsa_wb_req_t        wbReq,
  output lsa_wb_rsp_t             wbRsp,
  input  wire logic [NUM_LED-1:0] ledSet,
  input  wire logic [NUM_LED-1:0] ledAckSource,
  input  wire logic [NUM_RLY-1:0] relayOutputSet,
  input  wire logic [NUM_RLY-1:0] relayOutputAckSource,
  input  wire logic [NUM_SCD-1:0] scadaSet,
  input  wire logic [NUM_SG-1:0]  tripSet,
  input  wire logic [NUM_SG-1:0]  tripCommandAckSource,
  input  wire logic               allLedAckSource,
  input  wire logic               allRelayOutputAckSource,
  input  wire logic               allScadaAckSource,
  input  wire logic               scadaAckRequest,
  input  wire logic               protAlarm,
  output logic [NUM_LED-1:0]      ledOut,
  output logic [NUM_RLY-1:0]      relayOutput,
  output logic [NUM_SCD-1:0]      scadaOut,
  output logic [NUM_SG-1:0]       tripOut
);

  logic               remoteEn_reg;
  logic [NUM_LED-1:0] ledMode_reg;
  logic [OFF_W-1:0]   offDelay_reg;
  logic [NUM_LED-1:0] ledLatch_reg;
  logic [NUM_RLY-1:0] rlyLatch_reg;
  logic [NUM_SCD-1:0] scdLatch_reg;
  logic [NUM_SG-1:0]  trpLatch_reg;
  logic [NUM_LED-1:0] ledAckPrev_reg;
  logic [NUM_RLY-1:0] rlyAckPrev_reg;
  logic [NUM_SG-1:0]  trpAckPrev_reg;
  logic [3:0]         colPrev_reg;
  logic               alarmPrev_reg;
  logic [NUM_RLY-1:0] rlyPending_reg;
  logic [OFF_W-1:0]   offCnt_reg [NUM_RLY];
  logic [31:0]        tickCnt_reg;
  logic               tick_reg;
  logic               swLed_reg;
  logic               swRly_reg;
  logic               swScd_reg;

  function automatic logic [31:0] widen(input logic [63:0] v);
    widen = v[31:0];
  endfunction

  // Set wins; a clear that meets an active source is lost
  function automatic logic latchNext(input logic cur, input logic setIn,
                                     input logic clrIn);
    latchNext = setIn | (cur & ~clrIn);
  endfunction

  function automatic logic rise(input logic lvl, input logic prevLvl);
    rise = lvl & ~prevLvl;
  endfunction

  // Rising edges of every acknowledge source
  logic [NUM_LED-1:0] ledAckEv;
  logic [NUM_RLY-1:0] rlyAckEv;
  logic [NUM_SG-1:0]  trpAckEv;
  logic               allLedEv;
  logic               allRlyEv;
  logic               allScdEv;
  logic               scdReqEv;
  logic               alarmEv;
  logic [3:0]         colNow;

  assign colNow   = {scadaAckRequest, allScadaAckSource,
                     allRelayOutputAckSource, allLedAckSource};
  assign ledAckEv = ledAckSource & ~ledAckPrev_reg;
  assign rlyAckEv = relayOutputAckSource & ~rlyAckPrev_reg;
  assign trpAckEv = tripCommandAckSource & ~trpAckPrev_reg;
  // Collective paths gated by remote enable
  assign allLedEv = remoteEn_reg
                  & rise(colNow[0], colPrev_reg[0]);
  assign allRlyEv = remoteEn_reg
                  & rise(colNow[1], colPrev_reg[1]);
  assign allScdEv = remoteEn_reg
                  & rise(colNow[2], colPrev_reg[2]);
  assign scdReqEv = remoteEn_reg
                  & rise(colNow[3], colPrev_reg[3]);
  assign alarmEv  = rise(protAlarm, alarmPrev_reg);

  // Idle sources sit low, so previous levels reset to 0
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ledAckPrev_reg <= '0;
      rlyAckPrev_reg <= '0;
      trpAckPrev_reg <= '0;
      colPrev_reg    <= 4'h0;
      alarmPrev_reg  <= 1'h0;
    end else begin
      ledAckPrev_reg <= ledAckSource;
      rlyAckPrev_reg <= relayOutputAckSource;
      trpAckPrev_reg <= tripCommandAckSource;
      colPrev_reg    <= colNow;
      alarmPrev_reg  <= protAlarm;
    end
  end

  // Acknowledge requests per object, before the source-inactive check
  logic [NUM_LED-1:0] ledAckReq;
  logic [NUM_RLY-1:0] rlyAckReq;
  logic [NUM_SCD-1:0] scdAckReq;

  assign ledAckReq = ledAckEv
                   | {NUM_LED{allLedEv | swLed_reg}}
                   | (ledMode_reg & {NUM_LED{alarmEv}});
  assign rlyAckReq = rlyAckEv
                   | {NUM_RLY{allRlyEv | swRly_reg}};
  assign scdAckReq = {NUM_SCD{allScdEv | scdReqEv | swScd_reg}};

  // Per-object latches; set wins, clear needs source gone
  for (genvar i = 0; i < NUM_LED; i++) begin : g_led
    always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
        ledLatch_reg[i] <= 1'h0;
      end else begin
        ledLatch_reg[i] <= latchNext(ledLatch_reg[i], ledSet[i],
                                     ledAckReq[i]);
      end
    end
  end

  for (genvar i = 0; i < NUM_SCD; i++) begin : g_scd
    always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
        scdLatch_reg[i] <= 1'h0;
      end else begin
        scdLatch_reg[i] <= latchNext(scdLatch_reg[i], scadaSet[i],
                                     scdAckReq[i]);
      end
    end
  end

  for (genvar i = 0; i < NUM_SG; i++) begin : g_trp
    always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
        trpLatch_reg[i] <= 1'h0;
      end else begin
        trpLatch_reg[i] <= latchNext(trpLatch_reg[i], tripSet[i],
                                     trpAckEv[i]);
      end
    end
  end

  // Free-running base tick; a release may come up to one tick early
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tickCnt_reg <= 32'h0000_0000;
      tick_reg    <= 1'h0;
    end else if (tickCnt_reg == widen(64'(OFF_TICK_CYC - 1))) begin
      tickCnt_reg <= 32'h0000_0000;
      tick_reg    <= 1'h1;
    end else begin
      tickCnt_reg <= tickCnt_reg + 32'h0000_0001;
      tick_reg    <= 1'h0;
    end
  end

  // Relay latch: ack arms a pending release, timer must run out first
  // A set during the wait cancels the release; the ack is not kept
  for (genvar i = 0; i < NUM_RLY; i++) begin : g_rly
    always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
        rlyLatch_reg[i]   <= 1'h0;
        rlyPending_reg[i] <= 1'h0;
        offCnt_reg[i]     <= '0;
      end else if (relayOutputSet[i]) begin
        rlyLatch_reg[i]   <= 1'h1;
        rlyPending_reg[i] <= 1'h0;
        offCnt_reg[i]     <= '0;
      end else if (rlyPending_reg[i]) begin
        if (offCnt_reg[i] >= offDelay_reg) begin
          rlyLatch_reg[i]   <= 1'h0;
          rlyPending_reg[i] <= 1'h0;
        end else if (tick_reg) begin
          offCnt_reg[i] <= offCnt_reg[i] + {{(OFF_W-1){1'h0}}, 1'h1};
        end
      end else if (rlyAckReq[i] && rlyLatch_reg[i]) begin
        rlyPending_reg[i] <= 1'h1;
        offCnt_reg[i]     <= '0;
      end
    end
  end

  // Wishbone slave, one wait state then ack
  logic wbHit;
  logic wbWr;
  assign wbHit = wbReq.cyc & wbReq.stb & ~wbRsp.ack;
  // Writes land on the edge where the master sees ack, so an
  // abandoned cycle leaves the registers untouched
  assign wbWr  = wbReq.cyc & wbReq.stb & wbReq.we & wbRsp.ack;

  // Only byte lane 0 carries the control bits
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      remoteEn_reg <= REMOTE_EN_RST;
    end else if (wbWr && wbReq.adr == ADDR_CTRL && wbReq.sel[0]) begin
      remoteEn_reg <= wbReq.dat[CTRL_REMOTE_EN_BIT];
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ledMode_reg <= LED_MODE_RST[NUM_LED-1:0];
    end else if (wbWr && wbReq.adr == ADDR_LED_MODE) begin
      ledMode_reg <= wbReq.dat[NUM_LED-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      offDelay_reg <= OFFDELAY_RST[OFF_W-1:0];
    end else if (wbWr && wbReq.adr == ADDR_OFFDELAY) begin
      offDelay_reg <= wbReq.dat[OFF_W-1:0];
    end
  end

  // Software collective pulses, gated like SCADA requests
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      swLed_reg <= 1'h0;
      swRly_reg <= 1'h0;
      swScd_reg <= 1'h0;
    end else begin
      swLed_reg <= 1'h0;
      swRly_reg <= 1'h0;
      swScd_reg <= 1'h0;
      if (wbWr && wbReq.adr == ADDR_CTRL && wbReq.sel[0]
          && remoteEn_reg) begin
        swLed_reg <= wbReq.dat[CTRL_SW_ALL_LED];
        swRly_reg <= wbReq.dat[CTRL_SW_ALL_RLY];
        swScd_reg <= wbReq.dat[CTRL_SW_ALL_SCD];
      end
    end
  end

  // Read mux; unmapped offsets read as zero
  logic [31:0] rdData;
  always_comb begin
    rdData = 32'h0000_0000;
    unique case (wbReq.adr)
      ADDR_CTRL:      rdData[CTRL_REMOTE_EN_BIT] = remoteEn_reg;
      ADDR_LED_MODE:  rdData[NUM_LED-1:0] = ledMode_reg;
      ADDR_LED_LATCH: rdData[NUM_LED-1:0] = ledLatch_reg;
      ADDR_RLY_LATCH: rdData[NUM_RLY-1:0] = rlyLatch_reg;
      ADDR_SCD_LATCH: rdData[NUM_SCD-1:0] = scdLatch_reg;
      ADDR_TRP_LATCH: rdData[NUM_SG-1:0]  = trpLatch_reg;
      ADDR_OFFDELAY:  rdData[OFF_W-1:0]   = offDelay_reg;
      ADDR_STATUS:    rdData[NUM_RLY-1:0] = rlyPending_reg;
      default:        rdData = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wbRsp <= '0;
    end else begin
      wbRsp.ack <= wbHit;
      wbRsp.dat <= wbHit ? rdData : 32'h0000_0000;
    end
  end

  // Outputs straight from flops
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ledOut      <= '0;
      relayOutput <= '0;
      scadaOut    <= '0;
      tripOut     <= '0;
    end else begin
      ledOut      <= ledLatch_reg;
      relayOutput <= rlyLatch_reg;
      scadaOut    <= scdLatch_reg;
      tripOut     <= trpLatch_reg;
    end
  end

endmodule // lsa_latched_state_ack

// *** sim/lsa_src_model.sv ***
module lsa_src_model #(
  parameter int W    = 15,
  parameter int HOLD = 3
) (
  input  wire logic         ref_clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] kick,
  output logic      [W-1:0] src
);
  timeunit 1ns;
  timeprecision 1ps;
  // Contact closes for HOLD cycles, so a held source gives one edge
  logic [W-1:0] sh [HOLD];
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sh <= '{default: '0};
    end else begin
      sh[0] <= kick;
      for (int i = 1; i < HOLD; i++) sh[i] <= sh[i-1];
    end
  end
  always_comb begin
    src = '0;
    for (int i = 0; i < HOLD; i++) src = src | sh[i];
  end
endmodule // lsa_src_model

// *** sim/lsa_latched_state_ack_chk.sv ***
module lsa_latched_state_ack_chk
  import lsa_pkg::*;
#(
  parameter int NUM_LED = 16,
  parameter int NUM_RLY = 16,
  parameter int NUM_SCD = 16,
  parameter int NUM_SG  = 4
) (
  input wire logic               ref_clk,
  input wire logic               reset_n,
  input wire lsa_wb_req_t        wbReq,
  input wire lsa_wb_rsp_t        wbRsp,
  input wire logic [NUM_LED-1:0] ledSet,
  input wire logic [NUM_LED-1:0] ledOut,
  input wire logic [NUM_RLY-1:0] relayOutputSet,
  input wire logic [NUM_RLY-1:0] relayOutputAckSource,
  input wire logic [NUM_RLY-1:0] relayOutput,
  input wire logic [NUM_SCD-1:0] scadaSet,
  input wire logic [NUM_SCD-1:0] scadaOut,
  input wire logic [NUM_SG-1:0]  tripCommandAckSource,
  input wire logic [NUM_SG-1:0]  tripOut
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  property p_ackOne; wbRsp.ack |=> !wbRsp.ack; endproperty
  a_ackOne: assert property (p_ackOne)
    else $error("ack held");
  property p_ackNext; wbReq.cyc && wbReq.stb && !wbRsp.ack |=> wbRsp.ack;
  endproperty
  a_ackNext: assert property (p_ackNext)
    else $error("ack late");
  property p_ackWhy; wbRsp.ack |-> $past(wbReq.cyc && wbReq.stb); endproperty
  a_ackWhy: assert property (p_ackWhy)
    else $error("ack unasked");
  property p_datIdle; !wbRsp.ack |-> wbRsp.dat == 32'h0; endproperty
  a_datIdle: assert property (p_datIdle)
    else $error("data without ack");
  property p_ledSet; ledSet[0] |-> ##2 ledOut[0]; endproperty
  a_ledSet: assert property (p_ledSet)
    else $error("led not latched");
  property p_rlySet; relayOutputSet[0] |-> ##2 relayOutput[0]; endproperty
  a_rlySet: assert property (p_rlySet)
    else $error("relay not latched");
  property p_trpAck; $fell(tripOut[0]) |-> $past(tripCommandAckSource[0], 2)
    && !$past(tripCommandAckSource[0], 3); endproperty
  a_trpAck: assert property (p_trpAck)
    else $error("trip cleared without edge");
  property p_scdClr; $fell(scadaOut[0]) |-> !$past(scadaSet[0], 2); endproperty
  a_scdClr: assert property (p_scdClr)
    else $error("scada cleared while set");
  property p_rlyDly; $rose(relayOutputAckSource[0]) && relayOutput[0]
    |=> relayOutput[0] [*2]; endproperty
  a_rlyDly: assert property (p_rlyDly)
    else $error("relay released early");
endmodule // lsa_latched_state_ack_chk

bind lsa_latched_state_ack lsa_latched_state_ack_chk #(
  .NUM_LED(NUM_LED), .NUM_RLY(NUM_RLY), .NUM_SCD(NUM_SCD), .NUM_SG(NUM_SG)
) u_chk (.*);

// *** sim/lsa_latched_state_ack_tb.sv ***
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; \
  $display("unexpected %0t got %h want %h", $time, a, b); end end
module lsa_latched_state_ack_tb
  import lsa_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NL = 4, NR = 4, NS = 4, NG = 2;
  logic          ref_clk = 1'h0, reset_n = 1'h0;
  lsa_wb_req_t   wbReq = '0;
  lsa_wb_rsp_t   wbRsp;
  logic [NL-1:0] ledSet = '0, ledAckSource, ledOut;
  logic [NR-1:0] relayOutputSet = '0, relayOutputAckSource, relayOutput;
  logic [NS-1:0] scadaSet = '0, scadaOut;
  logic [NG-1:0] tripSet = '0, tripCommandAckSource, tripOut;
  logic          allLedAckSource, allRelayOutputAckSource, allScadaAckSource;
  logic          scadaAckRequest, protAlarm;
  logic [14:0]   kick = '0, src;
  logic [31:0]   rd;
  int            n_errors = 0, checked = 0;
  assign {protAlarm, scadaAckRequest, allScadaAckSource,
    allRelayOutputAckSource, allLedAckSource, tripCommandAckSource,
    relayOutputAckSource, ledAckSource} = src;
  initial forever #2.5 ref_clk = ~ref_clk;
  lsa_src_model #(.W(15), .HOLD(3)) u_src (.*);
  lsa_latched_state_ack #(.NUM_LED(NL), .NUM_RLY(NR), .NUM_SCD(NS),
    .NUM_SG(NG)) DUT (.*);
  task automatic end_sim();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    wbReq <= '{1'h1, 1'h1, w, 4'hF, a, d};
    do begin
      @(posedge ref_clk);
      n++;
    end while (wbRsp.ack !== 1'h1 && n < 50);
    rd = wbRsp.dat;
    wbReq <= '0;
    if (n >= 50) begin
      n_errors++;
      end_sim();
    end
  endtask
  task automatic pset();
    @(posedge ref_clk);
    {ledSet, relayOutputSet, scadaSet, tripSet} <= 14'h3FFF;
    @(posedge ref_clk);
    {ledSet, relayOutputSet, scadaSet, tripSet} <= 14'h0;
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic kk(input logic [14:0] v);
    @(posedge ref_clk);
    kick <= v;
    @(posedge ref_clk);
    kick <= 15'h0;
    repeat (8) @(posedge ref_clk);
  endtask
  task automatic co(input logic [3:0] l, r, s, input logic [1:0] t);
    `CHK(ledOut, l)
    `CHK(relayOutput, r)
    `CHK(scadaOut, s)
    `CHK(tripOut, t)
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'h1;
    co(4'h0, 4'h0, 4'h0, 2'h0);
    wb(1'h0, ADDR_CTRL, 32'h0);
    `CHK(rd, 32'h0)
    wb(1'h1, 8'h20, 32'hFFFF_FFFF);
    wb(1'h0, 8'h20, 32'h0);
    `CHK(rd, 32'h0)
    pset();
    co(4'hF, 4'hF, 4'hF, 2'h3);
    wb(1'h0, ADDR_LED_LATCH, 32'h0);
    `CHK(rd, 32'hF)
    kk(15'h0111);
    co(4'hE, 4'hE, 4'hF, 2'h2);
    ledSet <= 4'h2;
    kk(15'h0002);
    ledSet <= 4'h0;
    co(4'hE, 4'hE, 4'hF, 2'h2);
    kk(15'h7C00);
    co(4'hE, 4'hE, 4'hF, 2'h2);
    wb(1'h1, ADDR_CTRL, 32'h1);
    kk(15'h1000);
    co(4'hE, 4'hE, 4'h0, 2'h2);
    pset();
    kk(15'h2000);
    co(4'hF, 4'hF, 4'h0, 2'h3);
    kk(15'h0800);
    co(4'hF, 4'h0, 4'h0, 2'h3);
    kk(15'h0400);
    co(4'h0, 4'h0, 4'h0, 2'h3);
    wb(1'h1, ADDR_LED_MODE, 32'h5);
    wb(1'h0, ADDR_LED_MODE, 32'h0);
    `CHK(rd, 32'h5)
    pset();
    kk(15'h4000);
    co(4'hA, 4'hF, 4'hF, 2'h3);
    wb(1'h1, ADDR_CTRL, 32'hF);
    repeat (6) @(posedge ref_clk);
    co(4'h0, 4'h0, 4'h0, 2'h3);
    wb(1'h1, ADDR_OFFDELAY, 32'h1);
    pset();
    kk(15'h0010);
    wb(1'h0, ADDR_STATUS, 32'h0);
    `CHK(rd, 32'h1)
    co(4'hF, 4'hF, 4'hF, 2'h3);
    wb(1'h1, ADDR_OFFDELAY, 32'h0);
    repeat (6) @(posedge ref_clk);
    co(4'hF, 4'hE, 4'hF, 2'h3);
    end_sim();
  end
endmodule // lsa_latched_state_ack_tb
